// File: rtl/ciexe_consts.vh
// Purpose: Constants for the instruction execute slice
// Assumes: Included by the core and by its bench
// Notes: Byte offsets on the AHB-Lite bus, one word each
`ifndef CIEXE_CONSTS_VH
`define CIEXE_CONSTS_VH

// Register byte offsets
`define CIEXE_OFS_CMD 8'h00
`define CIEXE_OFS_ACC 8'h04
`define CIEXE_OFS_STATUS 8'h08
`define CIEXE_OFS_FADDR 8'h0C
`define CIEXE_OFS_FDATA 8'h10
`define CIEXE_OFS_DIR 8'h14
`define CIEXE_OFS_WDT 8'h18
`define CIEXE_OFS_WAKE 8'h1C

// Command word field positions
`define CIEXE_CMD_OP_LSB 0
`define CIEXE_CMD_FA_LSB 4
`define CIEXE_CMD_DST_BIT 11
`define CIEXE_CMD_LIT_LSB 12

// Operation codes
`define CIEXE_OP_NOP 4'h0
`define CIEXE_OP_ROT 4'h1
`define CIEXE_OP_LSUB 4'h2
`define CIEXE_OP_RSUB 4'h3
`define CIEXE_OP_RSUBB 4'h4
`define CIEXE_OP_SWAP 4'h5
`define CIEXE_OP_DIR 4'h6
`define CIEXE_OP_XORL 4'h7
`define CIEXE_OP_SLEEP 4'h8

// Status bit positions
`define CIEXE_ST_C 0
`define CIEXE_ST_DC 1
`define CIEXE_ST_Z 2
`define CIEXE_ST_TO 3
`define CIEXE_ST_PD 4
`define CIEXE_ST_SLP 5

// Direction register select operands
`define CIEXE_DIR_A 7'h05
`define CIEXE_DIR_B 7'h06
`define CIEXE_DIR_C 7'h07

// Reset values and the word hsize code
`define CIEXE_RST_DIR 8'hFF
`define CIEXE_RST_TO 1'b1
`define CIEXE_RST_PD 1'b1
`define CIEXE_HSIZE_WORD 3'h2
`endif

// File: rtl/ciexe_core.v
// Purpose: Execute slice of an 8-bit core behind an AHB-Lite slave
// Assumes: Single clock hclk, async active-low reset, word accesses only
// Notes: A write to the command register runs one instruction at once, and is ignored while asleep
`timescale 1ns/1ps
`include "ciexe_consts.vh"

module ciexe_core #(
    parameter FILE_DEPTH = 128,
    parameter PRE_W = 8,
    parameter WDT_W = 8
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Core side outputs
    output reg [7:0] port_a_direction,
    output reg [7:0] port_b_direction,
    output reg [7:0] port_c_direction,
    output reg sleep_state
);

    // Bus data phase bookkeeping
    reg pend_wr_r;
    reg pend_rd_r;
    reg [7:0] addr_r;
    reg addr_hit_r;

    // Core architectural state
    reg [7:0] acc_r;
    reg carry_r;
    reg nibble_carry_flag_r;
    reg zero_r;
    reg watchdog_expiry_bit_r;
    reg sleep_entered_bit_r;
    reg [6:0] faddr_r;
    reg [19:0] cmd_r;
    reg [7:0] file_mem [0:FILE_DEPTH-1];

    // Watchdog
    reg [PRE_W-1:0] prescaler_r;
    reg [WDT_W-1:0] watchdog_counter_r;

    // Decoded command fields from the write data
    wire [3:0] op = hwdata[`CIEXE_CMD_OP_LSB +: 4];
    wire [6:0] fa = hwdata[`CIEXE_CMD_FA_LSB +: 7];
    wire dst = hwdata[`CIEXE_CMD_DST_BIT];
    wire [7:0] lit = hwdata[`CIEXE_CMD_LIT_LSB +: 8];
    wire [7:0] fval = file_mem[fa];

    // Write data phase qualifiers and address phase accept
    wire wr_go = pend_wr_r & addr_hit_r;
    wire cmd_go = wr_go & (addr_r == `CIEXE_OFS_CMD) & ~sleep_state;
    wire addr_take = hsel & htrans[1] & hready;

    // Execution results
    reg [7:0] res;
    reg res_to_acc;
    reg res_to_file;
    reg upd_c;
    reg upd_dc;
    reg upd_z;
    reg new_c;
    reg new_dc;
    reg sleep_go;
    reg dir_go;
    reg [7:0] sub_a;
    reg [7:0] sub_b;
    reg sub_cin;
    reg [8:0] sub_sum;
    reg [4:0] sub_low;

    // Shared subtractor: a + ~b + cin, carry out is not-borrow
    always @* begin
        sub_a = fval;
        sub_b = acc_r;
        sub_cin = 1'b1;
        if (op == `CIEXE_OP_LSUB) begin
            sub_a = lit;
        end
        if (op == `CIEXE_OP_RSUBB) begin
            sub_cin = carry_r;
        end
        sub_sum = {1'b0, sub_a} + {1'b0, ~sub_b} + {8'h00, sub_cin};
        sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
    end

    // Instruction decode and result selection
    always @* begin
        res = 8'h00;
        res_to_acc = 1'b0;
        res_to_file = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        new_c = carry_r;
        new_dc = nibble_carry_flag_r;
        sleep_go = 1'b0;
        dir_go = 1'b0;
        if (cmd_go) begin
            case (op)
                `CIEXE_OP_ROT: begin
                    res = {carry_r, fval[7:1]};
                    new_c = fval[0];
                    upd_c = 1'b1;
                    res_to_acc = ~dst;
                    res_to_file = dst;
                end
                `CIEXE_OP_LSUB: begin
                    res = sub_sum[7:0];
                    new_c = sub_sum[8];
                    new_dc = sub_low[4];
                    upd_c = 1'b1;
                    upd_dc = 1'b1;
                    upd_z = 1'b1;
                    res_to_acc = 1'b1;
                end
                `CIEXE_OP_RSUB, `CIEXE_OP_RSUBB: begin
                    res = sub_sum[7:0];
                    new_c = sub_sum[8];
                    new_dc = sub_low[4];
                    upd_c = 1'b1;
                    upd_dc = 1'b1;
                    upd_z = 1'b1;
                    res_to_acc = ~dst;
                    res_to_file = dst;
                end
                `CIEXE_OP_SWAP: begin
                    res = {fval[3:0], fval[7:4]};
                    res_to_acc = ~dst;
                    res_to_file = dst;
                end
                `CIEXE_OP_DIR: begin
                    dir_go = 1'b1;
                end
                `CIEXE_OP_XORL: begin
                    res = acc_r ^ lit;
                    upd_z = 1'b1;
                    res_to_acc = 1'b1;
                end
                `CIEXE_OP_SLEEP: begin
                    sleep_go = 1'b1;
                end
                default: begin
                    res = 8'h00; // Unknown codes act as no operation
                end
            endcase
        end
    end

    // Watchdog prescaler tick, one cycle enable into the counter
    wire pre_tick = &prescaler_r;
    wire wdt_ovf = pre_tick & (&watchdog_counter_r);

    // Watchdog runs always; sleep entry restarts it from zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler_r <= {PRE_W{1'b0}};
            watchdog_counter_r <= {WDT_W{1'b0}};
        end else if (sleep_go) begin
            prescaler_r <= {PRE_W{1'b0}};
            watchdog_counter_r <= {WDT_W{1'b0}};
        end else begin
            prescaler_r <= prescaler_r + {{(PRE_W-1){1'b0}}, 1'b1};
            if (pre_tick) begin
                watchdog_counter_r <= watchdog_counter_r + {{(WDT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Register file: instruction write-back or direct bus window
    always @(posedge hclk) begin
        if (res_to_file) begin
            file_mem[fa] <= res;
        end else if (wr_go && addr_r == `CIEXE_OFS_FDATA) begin
            file_mem[faddr_r] <= hwdata[7:0];
        end
    end

    // Accumulator, flags, direction registers and sleep state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= 8'h00;
            carry_r <= 1'b0;
            nibble_carry_flag_r <= 1'b0;
            zero_r <= 1'b0;
            watchdog_expiry_bit_r <= `CIEXE_RST_TO;
            sleep_entered_bit_r <= `CIEXE_RST_PD;
            sleep_state <= 1'b0;
            faddr_r <= 7'h00;
            cmd_r <= 20'h00000;
            port_a_direction <= `CIEXE_RST_DIR;
            port_b_direction <= `CIEXE_RST_DIR;
            port_c_direction <= `CIEXE_RST_DIR;
        end else begin
            if (cmd_go) begin
                cmd_r <= hwdata[19:0];
            end
            if (res_to_acc) begin
                acc_r <= res;
            end else if (wr_go && addr_r == `CIEXE_OFS_ACC) begin
                acc_r <= hwdata[7:0];
            end
            if (upd_c) begin
                carry_r <= new_c;
            end else if (wr_go && addr_r == `CIEXE_OFS_STATUS) begin
                carry_r <= hwdata[`CIEXE_ST_C];
            end
            if (upd_dc) begin
                nibble_carry_flag_r <= new_dc;
            end else if (wr_go && addr_r == `CIEXE_OFS_STATUS) begin
                nibble_carry_flag_r <= hwdata[`CIEXE_ST_DC];
            end
            if (upd_z) begin
                zero_r <= (res == 8'h00);
            end else if (wr_go && addr_r == `CIEXE_OFS_STATUS) begin
                zero_r <= hwdata[`CIEXE_ST_Z];
            end
            // Sleep entry wins over a wake; watchdog overflow wakes with expiry cleared
            if (sleep_go) begin
                watchdog_expiry_bit_r <= 1'b1;
                sleep_entered_bit_r <= 1'b0;
                sleep_state <= 1'b1;
            end else begin
                if (sleep_state && wdt_ovf) begin
                    watchdog_expiry_bit_r <= 1'b0;
                    sleep_state <= 1'b0;
                end else if (wr_go && addr_r == `CIEXE_OFS_STATUS) begin
                    watchdog_expiry_bit_r <= hwdata[`CIEXE_ST_TO];
                end
                if (wr_go && addr_r == `CIEXE_OFS_STATUS) begin
                    sleep_entered_bit_r <= hwdata[`CIEXE_ST_PD];
                end
                if (wr_go && addr_r == `CIEXE_OFS_WAKE && hwdata[0]) begin
                    sleep_state <= 1'b0;
                end
            end
            if (wr_go && addr_r == `CIEXE_OFS_FADDR) begin
                faddr_r <= hwdata[6:0];
            end
            // Out-of-range operands leave all direction registers alone
            if (dir_go) begin
                case (fa)
                    `CIEXE_DIR_A: port_a_direction <= acc_r;
                    `CIEXE_DIR_B: port_b_direction <= acc_r;
                    `CIEXE_DIR_C: port_c_direction <= acc_r;
                    default: port_a_direction <= port_a_direction;
                endcase
            end
        end
    end

    // Read mux over current state
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        if (addr_hit_r) begin
            case (addr_r)
                `CIEXE_OFS_CMD: rd_mux = {12'h000, cmd_r};
                `CIEXE_OFS_ACC: rd_mux = {24'h000000, acc_r};
                `CIEXE_OFS_STATUS: begin
                    rd_mux[`CIEXE_ST_C] = carry_r;
                    rd_mux[`CIEXE_ST_DC] = nibble_carry_flag_r;
                    rd_mux[`CIEXE_ST_Z] = zero_r;
                    rd_mux[`CIEXE_ST_TO] = watchdog_expiry_bit_r;
                    rd_mux[`CIEXE_ST_PD] = sleep_entered_bit_r;
                    rd_mux[`CIEXE_ST_SLP] = sleep_state;
                end
                `CIEXE_OFS_FADDR: rd_mux = {25'h0000000, faddr_r};
                `CIEXE_OFS_FDATA: rd_mux = {24'h000000, file_mem[faddr_r]};
                `CIEXE_OFS_DIR: begin
                    rd_mux = {8'h00, port_c_direction, port_b_direction, port_a_direction};
                end
                `CIEXE_OFS_WDT: begin
                    rd_mux[15:8] = watchdog_counter_r[7:0];
                    rd_mux[7:0] = prescaler_r[7:0];
                end
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // AHB-Lite slave: writes zero wait, reads one wait so data comes from a flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_wr_r <= 1'b0;
            pend_rd_r <= 1'b0;
            addr_r <= 8'h00;
            addr_hit_r <= 1'b0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (pend_rd_r) begin
                hrdata <= rd_mux;
                hreadyout <= 1'b1;
                pend_rd_r <= 1'b0;
                pend_wr_r <= 1'b0;
            end else if (addr_take) begin
                addr_r <= haddr[7:0];
                addr_hit_r <= (haddr[31:8] == 24'h000000) && (hsize == `CIEXE_HSIZE_WORD);
                pend_wr_r <= hwrite;
                pend_rd_r <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                pend_wr_r <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end

endmodule

// File: tb/ciexe_core_assertions.sv
// Purpose: Port-level checker for the execute slice
// Assumes: One clock hclk, async active-low reset hresetn
// Notes: Sees only top-level ports; bound to every core instance
`timescale 1ns/1ps
module ciexe_core_chk (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus side
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // Core outputs
    input wire [7:0] port_a_direction,
    input wire [7:0] port_b_direction,
    input wire [7:0] port_c_direction,
    input wire sleep_state
);
    reg wr_ph_r;
    wire [23:0] dirs = {port_c_direction, port_b_direction, port_a_direction};
    // Marks a write data phase; the direction registers may only move at its closing edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_ph_r <= 1'b0;
        else wr_ph_r <= hsel & htrans[1] & hready & hwrite;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (s_rd_taken |=> s_one_wait)
        else $error("read wait not one cycle");
    a_ready_short: assert property (!hreadyout |=> hreadyout)
        else $error("ready low too long");
    a_dir_quiet: assert property (!wr_ph_r |=> $stable(dirs))
        else $error("direction moved without a write");
    a_dir_single: assert property ($onehot0({!$stable(port_a_direction),
        !$stable(port_b_direction), !$stable(port_c_direction)}))
        else $error("two directions moved together");
    // Sampled high means asleep through the cycle that ends here, so no load lands
    a_sleep_hold: assert property (sleep_state |-> $stable(dirs))
        else $error("direction moved while asleep");
    a_sleep_cause: assert property ($rose(sleep_state) |-> $past(wr_ph_r))
        else $error("sleep entered without a command");
    a_dir_reset: assert property ($past(!hresetn) |-> dirs == 24'hFFFFFF)
        else $error("direction reset value wrong");
endmodule

bind ciexe_core ciexe_core_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction), .sleep_state(sleep_state)
);

// File: tb/ciexe_core_tb_top.sv
// Purpose: Self-checking bench for the execute slice
// Assumes: Single slave, so hreadyout is fed back as hready
// Notes: Random operands from a fixed seed, a few forced corner cases
`timescale 1ns/1ps
`include "ciexe_consts.vh"
`define CHK(got_v, exp_v) begin num_checks = num_checks + 1; if ((got_v) !== (exp_v)) begin \
    err_total = err_total + 1; $display("BAD %0t got %h exp %h", $time, got_v, exp_v); end end
module cpu_instruction_execute_subset_tb_top;
    reg hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, q, r, cmd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sleep_state;
    wire [7:0] pa, pb, pc;
    integer seed = 32'h1AC1, err_total = 0, num_checks = 0, i;
    reg [3:0] op;
    reg [6:0] fa;
    reg [7:0] a, f, k;
    reg [2:0] fl;
    reg d;
    reg [10:0] e;
    reg [23:0] dexp = 24'hFFFFFF;
    ciexe_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(`CIEXE_HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc),
        .sleep_state(sleep_state));
    // Free-running 40 MHz clock
    always #12.5 hclk = ~hclk;
    // One whole transfer; hready is seen at the edge before updates land
    task bus(input w, input [31:0] ad, input [31:0] wd, output [31:0] rd);
        begin
            htrans <= 2'h2; haddr <= ad; hwrite <= w;
            @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0; hwdata <= wd;
            @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    // Expected {result, z, dc, c}
    function [10:0] exe_f(input [3:0] o, input [7:0] w, input [7:0] x0, input [7:0] l,
        input [2:0] s0);
        reg [8:0] s; reg [4:0] h; reg [7:0] x; reg ci;
        begin
            x = (o == `CIEXE_OP_LSUB) ? l : x0;
            ci = (o == `CIEXE_OP_RSUBB) ? s0[0] : 1'b1;
            s = x + {1'b0, ~w} + ci;
            h = x[3:0] + {1'b0, ~w[3:0]} + ci;
            case (o)
                4'h1: exe_f = {s0[0], x0[7:1], s0[2:1], x0[0]};
                4'h2, 4'h3, 4'h4: exe_f = {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
                4'h5: exe_f = {x0[3:0], x0[7:4], s0};
                4'h7: exe_f = {w ^ l, (w ^ l) == 8'h00, s0[1:0]};
                default: exe_f = {w, s0};
            endcase
        end
    endfunction
    task wrap_up;
        begin
            if (err_total == 0 && num_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // Watchdog against a hung handshake
    initial begin
        #(25 * 8000);
        err_total = err_total + 1;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, `CIEXE_OFS_STATUS, 0, q); `CHK(q, 32'h18)
        bus(0, `CIEXE_OFS_DIR, 0, q); `CHK(q, 32'hFFFFFF)
        for (i = 0; i < 60; i = i + 1) begin
            // Codes 0 to 7, so the no-operation code is drawn as well
            r = $random(seed); op = {1'b0, r[10:8]}; fa = r[6:0]; d = r[7];
            if (op == `CIEXE_OP_DIR) fa = 7'h04 + r[1:0];
            r = $random(seed); a = r[7:0]; f = r[15:8]; k = r[23:16]; fl = r[26:24];
            if (i == 0) begin // Equal operands give zero, no borrow
                a = f;
                op = `CIEXE_OP_RSUB;
            end
            if (i == 1) begin // Literal equal to accumulator
                k = a;
                op = `CIEXE_OP_LSUB;
            end
            if (i == 2) begin // Borrow form with carry clear
                fl[0] = 1'b0;
                op = `CIEXE_OP_RSUBB;
            end
            bus(1, `CIEXE_OFS_FADDR, fa, q); bus(1, `CIEXE_OFS_FDATA, f, q);
            bus(1, `CIEXE_OFS_ACC, a, q); bus(1, `CIEXE_OFS_STATUS, {27'h3, fl}, q);
            cmd = {12'h0, k, d, fa, op};
            bus(1, `CIEXE_OFS_CMD, cmd, q);
            e = exe_f(op, a, f, k, fl);
            if (d && (op == 4'h1 || op == 4'h3 || op == 4'h4 || op == 4'h5)) f = e[10:3];
            else a = e[10:3];
            if (op == `CIEXE_OP_DIR && fa == `CIEXE_DIR_A) dexp[7:0] = a;
            if (op == `CIEXE_OP_DIR && fa == `CIEXE_DIR_B) dexp[15:8] = a;
            if (op == `CIEXE_OP_DIR && fa == `CIEXE_DIR_C) dexp[23:16] = a;
            bus(0, `CIEXE_OFS_ACC, 0, q);
            `CHK(q, {24'h0, a})
            bus(0, `CIEXE_OFS_STATUS, 0, q);
            `CHK(q, {27'h3, e[2:0]})
            bus(0, `CIEXE_OFS_FDATA, 0, q); `CHK(q, {24'h0, f})
            bus(0, `CIEXE_OFS_DIR, 0, q); `CHK(q, {8'h0, dexp})
            `CHK({pc, pb, pa}, dexp)
        end
        // Sleep from expiry bit low and sleep entered bit high, so both must flip
        bus(1, `CIEXE_OFS_STATUS, {27'h2, fl}, q);
        bus(1, `CIEXE_OFS_CMD, {28'h0, `CIEXE_OP_SLEEP}, q);
        bus(0, `CIEXE_OFS_STATUS, 0, q); `CHK(q, {26'h0, 3'b101, fl})
        bus(0, `CIEXE_OFS_WDT, 0, q); `CHK(q[15:8], 8'h00)
        `CHK(q[7:0] < 8'h10, 1'b1)
        `CHK(sleep_state, 1'b1)
        bus(1, `CIEXE_OFS_CMD, {12'h0, 8'hFF, 8'h0, `CIEXE_OP_XORL}, q);
        bus(0, `CIEXE_OFS_ACC, 0, q); `CHK(q, {24'h0, a})
        bus(1, `CIEXE_OFS_WAKE, 32'h1, q);
        bus(0, 32'h100, 0, q); `CHK(q, 32'h0)
        `CHK(sleep_state, 1'b0)
        wrap_up;
    end
endmodule
